/* common/acp_pkg.sv */
// ==========================================================
// Command parser constants
package acp_pkg;
  localparam int SET_MAX = 4095;
  localparam int RESP_MAX = 65535;
  localparam int COLOUR_MAX = 255;
  localparam int COLOUR_SUBS = 3;
  localparam int SEL_SUBS_MAX = 5;
  localparam int CHAN_MAX = 4;
  localparam int ANLZ_MAX = 3;
  localparam int FLT_DEC_MAX = 99;
  localparam logic [7:0] C_NUL = 8'h00;
  localparam logic [7:0] C_TAB = 8'h09;
  localparam logic [7:0] C_LF = 8'h0A;
  localparam logic [7:0] C_FF = 8'h0C;
  localparam logic [7:0] C_CR = 8'h0D;
  localparam logic [7:0] C_SP = 8'h20;
  localparam logic [7:0] C_PLUS = 8'h2B;
  localparam logic [7:0] C_COMMA = 8'h2C;
  localparam logic [7:0] C_MINUS = 8'h2D;
  localparam logic [7:0] C_DOT = 8'h2E;
  localparam logic [7:0] C_ZERO = 8'h30;
  localparam logic [7:0] C_COLON = 8'h3A;
  localparam logic [7:0] C_SEMI = 8'h3B;
  localparam logic [7:0] C_Q = 8'h3F;
  localparam logic [7:0] C_A = 8'h41;
  localparam logic [7:0] C_E = 8'h45;
  localparam logic [7:0] C_US = 8'h5F;
  localparam logic [7:0] C_Z = 8'h7A;
  localparam logic [7:0] C_CUT = 8'h80;
  localparam logic [7:0] SYM_BASE = 8'h01;
  localparam logic [15:0] KW_CH = 16'h4348;
  localparam logic [23:0] KW_VPA = 24'h565041;
  localparam logic [3:0] K_ANY = 4'h0;
  localparam logic [3:0] K_TEXT = 4'h1;
  localparam logic [3:0] K_UINT = 4'h2;
  localparam logic [3:0] K_FLOAT = 4'h3;
  localparam logic [3:0] K_CHAN = 4'h4;
  localparam logic [3:0] K_ANLZ = 4'h5;
  localparam logic [3:0] K_COLOUR = 4'h6;
  localparam logic [3:0] K_RSEL = 4'h7;
  localparam logic [3:0] K_DSEL = 4'h8;
  typedef enum logic [2:0] {D_IDLE = 3'b001, D_READ = 3'b010, D_CHAR = 3'b100} acp_dec_t;

  function automatic logic is_term(input logic [7:0] c);
    return c == C_LF || c == C_CR || c == C_FF || c == C_NUL;
  endfunction
  function automatic logic is_ws(input logic [7:0] c);
    return c == C_SP || c == C_TAB || c == C_US;
  endfunction
  function automatic logic is_dig(input logic [7:0] c);
    return c >= C_ZERO && c <= 8'h39;
  endfunction
  function automatic logic [7:0] upc(input logic [7:0] c);
    return (c >= 8'h61 && c <= C_Z) ? c - C_SP : c;
  endfunction
  function automatic logic [7:0] sym_map(input logic [7:0] c);
    case (c)
      8'h21: sym_map = SYM_BASE;
      8'h5C: sym_map = SYM_BASE + 8'h1;
      8'h24: sym_map = SYM_BASE + 8'h2;
      8'h5E: sym_map = SYM_BASE + 8'h3;
      8'h5B: sym_map = SYM_BASE + 8'h4;
      8'h60: sym_map = SYM_BASE + 8'h5;
      8'h5D: sym_map = SYM_BASE + 8'h6;
      8'h27: sym_map = SYM_BASE + 8'h7;
      default: sym_map = c;
    endcase
  endfunction
endpackage

/* rtl/acp_parser.sv */
`timescale 1ns/1ps
// ==========================================================
// Overview of operation
// - Characters are 7-bit ASCII, top bit zero
// - Buffer input, decode only after terminator
// - Error skips this and later commands
// - LF, CR, FF, NUL end a set
// - Set holds at most 4095 characters
// - Empty set silently ignored
// - Semicolon splits commands; empty command ignored
// - Comma splits fields, colon splits sub-fields
// - Strip space, tab, underscore at edges
// - Keywords caseless; inner whitespace invalid
// - Text spans space to z, keeps delimiters
// - Eight text characters map to symbols
// - Unsigned digits only, 32-bit limit
// - Float: sign, point, exponent, 1e99
// - Analyzer selector: 1-3, An, VPAn, CHn
// - Channel selector: 1-4 or CH1-CH4
// - Result/display selector: one to five sub-fields
// - Colour: three sub-fields, each up to 255
// - Blank field holds only whitespace
// - Only query keywords produce responses
// - Responses comma-joined, CR LF, 65535 max
// - Query during pending response is overrun
module acp_parser
  import acp_pkg::*;
#(
  parameter int DEPTH = 8192
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic [3:0] fld_kind,
  input wire logic exec_busy,
  input wire logic exec_err,
  output logic fld_valid,
  output logic fld_last,
  output logic [7:0] fld_index,
  output logic [2:0] fld_sub,
  output logic fld_blank,
  output logic fld_uint_ok,
  output logic [31:0] fld_uint,
  output logic fld_float_ok,
  output logic [2:0] fld_chan,
  output logic [1:0] fld_anlz,
  output logic txt_valid,
  output logic [7:0] txt_data,
  output logic cmd_go,
  output logic cmd_query,
  output logic err_syntax,
  output logic err_range,
  output logic err_overrun,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import acp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // Whole set plus cut marker plus terminator must fit, else a full buffer deadlocks
  if (DEPTH < SET_MAX + 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("DEPTH must be a power of two above SET_MAX+1");
  end

  // ==========================================================
  // Receive buffer
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr, rd;
  logic [AW:0] used, nterm;
  logic [11:0] rx_len;
  logic rx_cut;
  logic [7:0] c;
  acp_dec_t st;
  logic rx_take, rx_t, rx_store, rd_take;
  logic [7:0] rx_byte;

  assign rx_ready = used != (AW+1)'(DEPTH);
  assign rx_take = rx_valid && rx_ready;
  assign rx_t = is_term(rx_data);
  assign rx_store = rx_take && (rx_t || !rx_cut);
  // Overlong set leaves a top-bit marker, rejected later as a bad character
  assign rx_byte = (!rx_t && rx_len == 12'(SET_MAX)) ? C_CUT : rx_data;
  assign rd_take = st == D_READ;

  always_ff @(posedge clk_sys)
  begin
    if (rx_store)
      mem[wr] <= rx_byte;
    if (rd_take)
      c <= mem[rd];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr <= '0;
      rd <= '0;
      used <= '0;
      nterm <= '0;
      rx_len <= '0;
      rx_cut <= 1'b0;
    end
    else
    begin
      if (rx_store)
        wr <= wr + 1'b1;
      if (rd_take)
        rd <= rd + 1'b1;
      used <= used + (AW+1)'(rx_store) - (AW+1)'(rd_take);
      nterm <= nterm + (AW+1)'(rx_store && rx_t) - (AW+1)'(rd_take && is_term(mem[rd]));
      if (rx_take)
      begin
        if (rx_t)
        begin
          rx_len <= '0;
          rx_cut <= 1'b0;
        end
        else if (!rx_cut)
        begin
          if (rx_len == 12'(SET_MAX))
            rx_cut <= 1'b1;
          else
            rx_len <= rx_len + 12'h1;
        end
      end
    end
  end

  // ==========================================================
  // Decode sequencer, one character per three cycles
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st <= D_IDLE;
    else
      case (st)
        D_IDLE: if (nterm != '0 && !exec_busy) st <= D_READ;
        D_READ: st <= D_CHAR;
        D_CHAR: st <= D_IDLE;
        default: st <= D_IDLE;
      endcase
  end

  // ==========================================================
  // Character classes
  logic dchar, tm, cend, txt, fend, send, ws;
  logic seen, tail, inws, u_ovf, u_ok, f_bad, f_dig, f_dot, f_e, f_ed, f_pos, f_en;
  logic [31:0] u_acc;
  logic [12:0] f_id;
  logic [7:0] f_ev, ev_nx, dgt;
  logic [31:0] kw;
  logic [2:0] klen, nsub, nsub_now, chan_v;
  logic [1:0] anlz_v;
  logic [7:0] fidx;
  logic col_syn, col_rng, cmd_err, cmd_q, skip, set_q;
  logic [35:0] u_nx;
  logic [15:0] ev_w;
  logic [13:0] f_mag;
  logic sub_uint, flt_ok, kdig, ch_kw, syn, rng, err_now, empty, q_now, ovr, go_now;
  logic rsp_act;

  assign dchar = st == D_CHAR;
  assign tm = is_term(c);
  assign cend = tm || c == C_SEMI;
  assign txt = fld_kind == K_TEXT && fidx != 8'h0;
  assign fend = cend || (!txt && c == C_COMMA);
  assign send = fend || (!txt && c == C_COLON);
  assign ws = is_ws(c) && !txt;

  assign u_nx = {4'h0, u_acc} * 36'hA + {28'h0, c - C_ZERO};
  assign ev_w = {8'h0, f_ev} * 16'hA + {8'h0, c - C_ZERO};
  assign ev_nx = ev_w > 16'hFF ? 8'hFF : ev_w[7:0];

  // ==========================================================
  // Sub-field scanner
  always_ff @(posedge clk_sys)
  begin
    if (srst || (dchar && send))
    begin
      seen <= 1'b0;
      tail <= 1'b0;
      inws <= 1'b0;
      u_acc <= '0;
      u_ovf <= 1'b0;
      u_ok <= 1'b1;
      f_bad <= 1'b0;
      f_dig <= 1'b0;
      f_dot <= 1'b0;
      f_e <= 1'b0;
      f_ed <= 1'b0;
      f_pos <= 1'b1;
      f_en <= 1'b0;
      f_id <= '0;
      f_ev <= '0;
      kw <= '0;
      klen <= '0;
    end
    else if (dchar && ws)
    begin
      if (seen)
        tail <= 1'b1;
    end
    else if (dchar)
    begin
      seen <= 1'b1;
      inws <= inws | tail;
      kw <= {kw[23:0], upc(c)};
      if (klen != 3'h7)
        klen <= klen + 3'h1;
      u_ok <= u_ok & is_dig(c);
      if (is_dig(c))
      begin
        u_acc <= u_nx[31:0];
        u_ovf <= u_ovf | (u_nx[35:32] != 4'h0);
      end
      f_pos <= upc(c) == C_E && f_dig && !f_e;
      if (is_dig(c))
      begin
        if (f_e)
        begin
          f_ed <= 1'b1;
          f_ev <= ev_nx;
        end
        else
        begin
          f_dig <= 1'b1;
          if (!f_dot && (f_id != '0 || c != C_ZERO))
            f_id <= f_id + 13'h1;
        end
      end
      else if ((c == C_PLUS || c == C_MINUS) && f_pos)
      begin
        if (f_e)
          f_en <= c == C_MINUS;
      end
      else if (c == C_DOT && !f_dot && !f_e)
        f_dot <= 1'b1;
      else if (upc(c) == C_E && f_dig && !f_e)
        f_e <= 1'b1;
      else
        f_bad <= 1'b1;
    end
  end

  // ==========================================================
  // Field checks
  assign sub_uint = seen && u_ok && !u_ovf;
  assign f_mag = {1'b0, f_id} + (f_en ? 14'h0 : {6'h0, f_ev});
  assign flt_ok = seen && !f_bad && f_dig && (!f_e || f_ed) && f_mag <= 14'(FLT_DEC_MAX + 1);
  assign dgt = kw[7:0] - C_ZERO;
  assign kdig = is_dig(kw[7:0]) && dgt != 8'h0;
  assign ch_kw = klen == 3'h3 && kw[23:8] == KW_CH && kdig && dgt <= 8'(CHAN_MAX);
  assign chan_v = (sub_uint && u_acc != '0 && u_acc <= 32'(CHAN_MAX)) ? u_acc[2:0] :
                  ch_kw ? dgt[2:0] : 3'h0;
  assign anlz_v = (sub_uint && u_acc != '0 && u_acc <= 32'(ANLZ_MAX)) ? u_acc[1:0] :
                  (kdig && dgt <= 8'(ANLZ_MAX) && ((klen == 3'h2 && kw[15:8] == C_A) ||
                  (klen == 3'h4 && kw[31:8] == KW_VPA))) ? dgt[1:0] : 2'h0;
  assign nsub_now = nsub + 3'h1;

  always_comb
  begin
    syn = c[7] || (txt && !cend && (c < C_SP || c > C_Z));
    rng = 1'b0;
    if (send && !txt && inws && (fidx == 8'h0 || fld_kind != K_ANY))
      syn = 1'b1;
    if (fend && !cend && fidx == 8'h0 && !seen)
      syn = 1'b1;
    if (fend && fidx != 8'h0)
      case (fld_kind)
        K_UINT: syn = syn || !sub_uint || nsub != 3'h0;
        K_FLOAT: syn = syn || !flt_ok || nsub != 3'h0;
        K_CHAN: syn = syn || chan_v == 3'h0 || nsub != 3'h0;
        K_ANLZ: syn = syn || (anlz_v == 2'h0 && !ch_kw) || nsub != 3'h0;
        K_COLOUR:
        begin
          syn = syn || col_syn || !sub_uint || nsub_now != 3'(COLOUR_SUBS);
          rng = col_rng || u_acc > 32'(COLOUR_MAX);
        end
        K_RSEL, K_DSEL: syn = syn || nsub_now > 3'(SEL_SUBS_MAX) || (nsub == 3'h0 && !seen);
        default: syn = syn;
      endcase
    if (!dchar || skip || cmd_err)
    begin
      syn = 1'b0;
      rng = 1'b0;
    end
  end

  assign err_now = cmd_err || syn || rng || exec_err;
  assign empty = fidx == 8'h0 && !seen;
  assign q_now = fidx == 8'h0 ? (seen && kw[7:0] == C_Q) : cmd_q;
  // Only a response from an earlier set counts; this set's own are joined
  assign ovr = q_now && rsp_act && !set_q;
  assign go_now = dchar && cend && !empty && !skip && !err_now && !ovr;

  // ==========================================================
  // Field and command state
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      nsub <= '0;
      col_syn <= 1'b0;
      col_rng <= 1'b0;
      fidx <= '0;
      cmd_err <= 1'b0;
      cmd_q <= 1'b0;
      skip <= 1'b0;
      set_q <= 1'b0;
    end
    else
    begin
      if (dchar && fend)
      begin
        nsub <= '0;
        col_syn <= 1'b0;
        col_rng <= 1'b0;
      end
      else if (dchar && send)
      begin
        if (nsub != 3'h6)
          nsub <= nsub_now;
        col_syn <= col_syn | !sub_uint;
        col_rng <= col_rng | (u_acc > 32'(COLOUR_MAX));
      end
      if (dchar && fend && fidx == 8'h0)
        cmd_q <= q_now;
      if (dchar && cend)
        fidx <= '0;
      else if (dchar && fend && fidx != 8'hFF)
        fidx <= fidx + 8'h1;
      if (dchar && cend)
        cmd_err <= 1'b0;
      else if (!skip && (syn || rng || exec_err))
        cmd_err <= 1'b1;
      if (go_now && q_now)
        set_q <= 1'b1;
      if (dchar && cend && !empty && (err_now || ovr))
        skip <= 1'b1;
      if (dchar && tm)
      begin
        skip <= 1'b0;
        set_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Field, command and error outputs
  logic set_done_q, fld_now;

  assign fld_now = dchar && send && !skip && !cmd_err && !(cend && empty);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      fld_valid <= 1'b0;
      fld_last <= 1'b0;
      fld_index <= '0;
      fld_sub <= '0;
      fld_blank <= 1'b0;
      fld_uint_ok <= 1'b0;
      fld_uint <= '0;
      fld_float_ok <= 1'b0;
      fld_chan <= '0;
      fld_anlz <= '0;
      txt_valid <= 1'b0;
      txt_data <= '0;
      cmd_go <= 1'b0;
      cmd_query <= 1'b0;
      err_syntax <= 1'b0;
      err_range <= 1'b0;
      err_overrun <= 1'b0;
      set_done_q <= 1'b0;
    end
    else
    begin
      fld_valid <= fld_now;
      fld_last <= fld_now && fend;
      if (dchar && send)
      begin
        fld_index <= fidx;
        fld_sub <= nsub;
        fld_blank <= !seen;
        fld_uint_ok <= sub_uint;
        fld_uint <= u_acc;
        fld_float_ok <= flt_ok;
        fld_chan <= chan_v;
        fld_anlz <= anlz_v;
      end
      txt_valid <= dchar && txt && !cend && !skip && !cmd_err && !syn;
      if (dchar)
        txt_data <= sym_map(c);
      cmd_go <= go_now;
      cmd_query <= go_now && q_now;
      err_syntax <= syn;
      err_range <= rng || (exec_err && !skip);
      err_overrun <= dchar && cend && !empty && !skip && !err_now && ovr;
      set_done_q <= dchar && tm && (set_q || (go_now && q_now));
    end
  end

  // ==========================================================
  // Response framing
  logic tx_free, room, comma_pend, end_pend;
  logic [1:0] crlf;
  logic [7:0] qpend;
  logic [15:0] rcnt;

  assign tx_free = !tx_valid || tx_ready;
  assign room = rcnt < 16'(RESP_MAX - 2);
  assign resp_ready = tx_free && crlf == 2'h0 && !comma_pend;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      comma_pend <= 1'b0;
      end_pend <= 1'b0;
      crlf <= '0;
      qpend <= '0;
      rcnt <= '0;
      rsp_act <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      qpend <= qpend + 8'(cmd_go && cmd_query) - 8'(resp_valid && resp_ready && resp_last);
      if (tx_free)
      begin
        if (crlf != 2'h0)
        begin
          tx_valid <= 1'b1;
          tx_data <= crlf == 2'h1 ? C_CR : C_LF;
          crlf <= crlf == 2'h1 ? 2'h2 : 2'h0;
        end
        else if (resp_valid && comma_pend)
        begin
          comma_pend <= 1'b0;
          if (room)
          begin
            tx_valid <= 1'b1;
            tx_data <= C_COMMA;
            rcnt <= rcnt + 16'h1;
          end
        end
        else if (resp_valid)
        begin
          comma_pend <= resp_last;
          // Bytes beyond the length cap are drained, not sent
          if (room)
          begin
            tx_valid <= 1'b1;
            tx_data <= {1'b0, resp_data[6:0]};
            rcnt <= rcnt + 16'h1;
          end
        end
        else if (end_pend && qpend == 8'h0)
        begin
          crlf <= 2'h1;
          end_pend <= 1'b0;
          comma_pend <= 1'b0;
          rcnt <= '0;
        end
      end
      if (set_done_q)
        end_pend <= 1'b1;
      if (tx_valid && tx_ready && tx_data == C_LF)
        rsp_act <= 1'b0;
      if (cmd_go && cmd_query)
        rsp_act <= 1'b1;
    end
  end
endmodule // acp_parser

/* tb/acp_parser_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// Port-level checks for the command parser
module acp_parser_chk
  import acp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic exec_err,
  input wire logic fld_valid,
  input wire logic fld_last,
  input wire logic [2:0] fld_chan,
  input wire logic txt_valid,
  input wire logic [7:0] txt_data,
  input wire logic cmd_go,
  input wire logic cmd_query,
  input wire logic err_syntax,
  input wire logic err_range,
  input wire logic err_overrun,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // Response ending steps
  sequence s_cr_taken;
    tx_valid && tx_ready && tx_data == C_CR;
  endsequence
  sequence s_lf_shown;
    tx_valid && tx_data == C_LF;
  endsequence
  // ==========================================================
  // Properties
  property p_tx_msb;
    tx_valid |-> !tx_data[7];
  endproperty
  property p_crlf;
    s_cr_taken |-> ##[1:4] s_lf_shown;
  endproperty
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_query_go;
    cmd_query |-> cmd_go;
  endproperty
  property p_go_clean;
    cmd_go |-> !(err_syntax || err_range || err_overrun);
  endproperty
  property p_exec_err;
    exec_err |=> err_range;
  endproperty
  property p_syn_pulse;
    err_syntax |=> !err_syntax;
  endproperty
  property p_rng_pulse;
    err_range |=> !err_range;
  endproperty
  property p_ovr_pulse;
    err_overrun |=> !err_overrun;
  endproperty
  property p_last;
    fld_last |-> fld_valid;
  endproperty
  property p_chan;
    fld_valid |-> fld_chan <= 3'h4;
  endproperty
  // Substituted characters must never leak through unmapped
  property p_txt_map;
    txt_valid |-> !(txt_data inside {8'h21, 8'h5C, 8'h24, 8'h5E, 8'h5B, 8'h60, 8'h5D, 8'h27}) && txt_data <= C_Z;
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("response byte with top bit set");
  a_crlf: assert property (p_crlf) else $error("line feed missing after carriage return");
  a_tx_hold: assert property (p_tx_hold) else $error("response byte changed while stalled");
  a_query_go: assert property (p_query_go) else $error("query flag without command");
  a_go_clean: assert property (p_go_clean) else $error("command issued alongside an error");
  a_exec_err: assert property (p_exec_err) else $error("executor error not reported");
  a_syn_pulse: assert property (p_syn_pulse) else $error("syntax strobe too long");
  a_rng_pulse: assert property (p_rng_pulse) else $error("range strobe too long");
  a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun strobe too long");
  a_last: assert property (p_last) else $error("field end without sub-field end");
  a_chan: assert property (p_chan) else $error("channel number out of range");
  a_txt_map: assert property (p_txt_map) else $error("text character not mapped");
endmodule // acp_parser_chk

bind acp_parser acp_parser_chk u_chk (.clk_sys, .srst, .exec_err, .fld_valid, .fld_last, .fld_chan, .txt_valid,
  .txt_data, .cmd_go, .cmd_query, .err_syntax, .err_range, .err_overrun, .tx_valid, .tx_data, .tx_ready);

/* tb/acp_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host model: sends command bytes, takes response bytes
module acp_host (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic [3:0] stall
);
  logic [7:0] sq[$];
  logic [7:0] got[$];
  logic [3:0] gap;
  task automatic put(input string s, input logic [7:0] t);
    byte b;
    foreach (s[i])
    begin
      b = s[i];
      sq.push_back({1'b0, b[6:0]});
    end
    sq.push_back(t);
  endtask
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h55;
    tx_ready = 1'b0;
    gap = 4'h0;
    forever
    begin
      @(posedge clk_sys);
      if (rx_valid && rx_ready)
        void'(sq.pop_front());
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
      #1;
      rx_valid = sq.size() > 0;
      // Idle data toggles so a stale byte cannot pass for a fresh one
      rx_data = (sq.size() > 0) ? sq[0] : ~rx_data;
      gap = (gap >= stall) ? 4'h0 : gap + 4'h1;
      tx_ready = (gap == 4'h0);
    end
  end
endmodule // acp_host

/* tb/acp_parser_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the command parser
module acp_parser_test;
  import acp_pkg::*;
  logic clk_sys, srst, rx_valid, rx_ready, exec_busy, exec_err, fld_valid, fld_last, fld_blank, fld_uint_ok;
  logic fld_float_ok, txt_valid, cmd_go, cmd_query, err_syntax, err_range, err_overrun, e, inj;
  logic resp_valid, resp_last, resp_ready, tx_valid, tx_ready, cap_ok;
  logic [7:0] rx_data, fld_index, txt_data, resp_data, tx_data;
  logic [3:0] fld_kind, stall;
  logic [2:0] fld_sub, fld_chan, cap_chan;
  logic [1:0] fld_anlz, cap_anlz;
  logic [31:0] fld_uint, cap_uint;
  logic [7:0] txq[$];
  logic [7:0] rq[$];
  int mismatches, checks, n_go, n_q, n_err, n_ovr, n_blank, n_fld, n_last, n_resp;

  acp_parser DUT (.clk_sys, .srst, .rx_valid, .rx_data, .rx_ready, .fld_kind, .exec_busy, .exec_err,
    .fld_valid, .fld_last, .fld_index, .fld_sub, .fld_blank, .fld_uint_ok, .fld_uint, .fld_float_ok,
    .fld_chan, .fld_anlz, .txt_valid, .txt_data, .cmd_go, .cmd_query, .err_syntax, .err_range,
    .err_overrun, .resp_valid, .resp_data, .resp_last, .resp_ready, .tx_valid, .tx_data, .tx_ready);
  acp_host host (.clk_sys, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .stall);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Monitor and executor stand-in
  initial
  begin
    exec_err = 1'b0;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    resp_last = 1'b1;
    forever
    begin
      @(posedge clk_sys);
      e = inj && fld_valid && fld_last && fld_index == 8'h00;
      if (!srst)
      begin
        n_go += cmd_go;
        n_q += cmd_go && cmd_query;
        n_err += err_syntax + err_range;
        n_ovr += err_overrun;
        n_blank += fld_valid && fld_blank;
        n_fld += fld_valid;
        n_last += fld_valid && fld_last;
        if (txt_valid)
          txq.push_back(txt_data);
        if (fld_valid && fld_index == 8'h01)
        begin
          cap_ok = (fld_kind == K_FLOAT) ? fld_float_ok : fld_uint_ok;
          cap_uint = fld_uint;
          cap_chan = fld_chan;
          cap_anlz = fld_anlz;
        end
        if (cmd_go && cmd_query)
        begin
          rq.push_back(8'h31 + 8'(n_resp));
          n_resp++;
        end
      end
      if (resp_valid && resp_ready)
        void'(rq.pop_front());
      #1;
      exec_err = e;
      resp_valid = rq.size() > 0;
      resp_data = (rq.size() > 0) ? rq[0] : ~resp_data;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic clear();
    @(posedge clk_sys);
    #1;
    {n_go, n_q, n_err, n_ovr, n_blank, n_fld, n_last, n_resp} = '0;
    txq.delete();
    host.got.delete();
  endtask
  // Decode costs three cycles a character, so the wait scales with length
  task automatic settle(input int len);
    for (int i = 0; i < 20000 && host.sq.size() > 0; i++)
      @(posedge clk_sys);
    repeat (3 * len + 40) @(posedge clk_sys);
    #1;
  endtask
  task automatic run(input string s, input logic [3:0] k, input int go, input int er, input logic [7:0] t = C_LF);
    clear();
    fld_kind = k;
    host.put(s, t);
    settle(s.len() + 1);
    check(n_go, go, "commands");
    check(n_err, er, "errors");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_sets();
    logic [7:0] tm [4] = '{C_LF, C_CR, C_FF, C_NUL};
    foreach (tm[i])
      run("A", K_ANY, 1, 0, tm[i]);
    run("", K_ANY, 0, 0);
    run(";;A;;B;", K_ANY, 2, 0);
    run(" k4_ ", K_ANY, 1, 0);
    run("K1;K 2;K3", K_ANY, 1, 1);
    run("aB,1,2:3", K_ANY, 1, 0);
    check(n_fld, 4, "sub-fields");
    check(n_last, 3, "fields");
    inj = 1'b1;
    run("E,1;G", K_ANY, 0, 1);
    inj = 1'b0;
  endtask
  task automatic t_fields();
    run("U,4294967295", K_UINT, 1, 0);
    check(cap_uint, 32'hFFFFFFFF, "uint value");
    check(cap_ok, 1'b1, "uint ok");
    run("U,4294967296", K_UINT, 0, 1);
    run("U,-5", K_UINT, 0, 1);
    run("F,+1.2345678e-6", K_FLOAT, 1, 0);
    run("F, -10.0E+3 ", K_FLOAT, 1, 0);
    run("F,1e99", K_FLOAT, 1, 0);
    check(cap_ok, 1'b1, "float ok");
    run("F,1e100", K_FLOAT, 0, 1);
    check(cap_ok, 1'b0, "float range");
    run("C,ch3", K_CHAN, 1, 0);
    check(cap_chan, 3'h3, "channel");
    run("C,4", K_CHAN, 1, 0);
    check(cap_chan, 3'h4, "channel");
    run("V,vpa2", K_ANLZ, 1, 0);
    check(cap_anlz, 2'h2, "analyzer");
    run("V,a3", K_ANLZ, 1, 0);
    check(cap_anlz, 2'h3, "analyzer");
    run("X,255:0:9", K_COLOUR, 1, 0);
    run("X,256:0:0", K_COLOUR, 0, 1);
    run("X,1:2", K_COLOUR, 0, 1);
    run("R,a:b:c:d:e", K_RSEL, 1, 0);
    run("R,a:b:c:d:e:f", K_RSEL, 0, 1);
    run("D,a:b:c:d:e:f", K_DSEL, 0, 1);
    run("B, _ ,x", K_ANY, 1, 0);
    check(n_blank, 1, "blank fields");
  endtask
  task automatic t_text();
    logic [7:0] ex [7] = '{8'h61, SYM_BASE, 8'h62, C_COLON, C_COMMA, SYM_BASE + 8'h02, C_Z};
    run("T,a!b:,$z", K_TEXT, 1, 0);
    check(txq.size(), 7, "text length");
    foreach (ex[i])
      check(txq[i], ex[i], "text char");
  endtask
  task automatic t_busy();
    clear();
    exec_busy = 1'b1;
    host.put("A", C_LF);
    repeat (40) @(posedge clk_sys);
    check(n_go, 0, "held decode");
    #1;
    exec_busy = 1'b0;
    settle(2);
    check(n_go, 1, "released decode");
  endtask
  task automatic t_query();
    string ex = "1,2\r\n";
    stall = 4'h2;
    run("N", K_ANY, 1, 0);
    check(host.got.size(), 0, "silent command");
    run("Q?;N;P?", K_ANY, 3, 0);
    check(n_q, 2, "queries");
    for (int i = 0; i < 2000 && host.got.size() < 5; i++)
      @(posedge clk_sys);
    check(host.got.size(), 5, "reply length");
    foreach (ex[i])
      check(host.got[i], ex[i], "reply byte");
  endtask
  task automatic t_over();
    clear();
    stall = 4'hF;
    fld_kind = K_ANY;
    host.put("Q?", C_LF);
    for (int i = 0; i < 3000 && host.got.size() < 1; i++)
      @(posedge clk_sys);
    #1;
    host.put("R?", C_LF);
    for (int i = 0; i < 3000 && host.got.size() < 3; i++)
      @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    check(n_ovr, 1, "overrun");
    check(n_go, 1, "commands");
    check(host.got.size(), 3, "reply length");
    #1;
    stall = 4'h0;
  endtask
  task automatic t_long();
    string s;
    for (int n = 4093; n <= 4094; n++)
    begin
      s = "T,";
      repeat (n) s = {s, "x"};
      run(s, K_TEXT, 4094 - n, n - 4093);
    end
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    srst = 1'b1;
    fld_kind = K_ANY;
    exec_busy = 1'b0;
    stall = 4'h0;
    inj = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_sets();
    t_fields();
    t_text();
    t_busy();
    t_query();
    t_over();
    t_long();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
endmodule // acp_parser_test
